// File: core/rrh_regs.sv
// Read-request header and read-path status register bank, APB slave.
// Assumes the read-path packetizer drives its load pulses on pclk.
//
// Function
// [R1] View select 10b shows the read-request header on words E8h-F4h.
// [R2] View select 11b shows packetizer status on the same four words.
// [R3] Header words reset to zero unless stated; bus reset leaves them.
// [R4] Status words reset to zero; bus reset leaves them untouched.
// [R5] Header word 0 resets to 0001 0010h.
// [R6] Word 0 speed code field, default 1h, kept over bus reset.
// [R7] Word 0 transaction label field of the outgoing read request.
// [R8] Word 0 retry code field of the outgoing read request.
// [R9] Word 0 tCode, default 1h, forced to 1h while read packetizer enabled; the code forces it from the cycle after the enable is set.
// [R10] Word 0 priority field of the outgoing read request.
// [R11] Word 1 holds destination node and upper destination offset.
// [R12] Word 2 holds the full lower destination offset.
// [R13] Word 3 resets to 0008 0000h; length field defaults to 8h.
// [R14] Word 3 lower half holds the extended tCode.
// [R15] Words 1-3 writable only while transmit packetizer is disabled.
// [R16] Completion state codes: 0 ok, 1 split, 2 ack, 4 page, 7 ... Dh.
// [R17] Status fields read-only; updated on transaction or page completion.
//
// Added by the designer: register access over APB.
`timescale 1ns/10ps
module rrh_regs (
    // Clock and reset
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    // APB slave
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [rrh_pkg::ADDR_W-1:0] paddr,
    input  wire logic [rrh_pkg::DATA_W-1:0] pwdata,
    output logic      [rrh_pkg::DATA_W-1:0] prdata,
    output logic                            pready,
    output logic                            pslverr,
    // Header load from the read packetizer
    input  wire logic                       hdr_load,
    input  wire logic [1:0]                 hdr_speed,
    input  wire logic [5:0]                 hdr_label,
    input  wire logic [1:0]                 hdr_retry,
    input  wire logic [3:0]                 hdr_tcode,
    input  wire logic [3:0]                 hdr_priority,
    // Transaction completion
    input  wire logic                       xfer_done,
    input  wire logic [3:0]                 xfer_state,
    input  wire logic [3:0]                 xfer_response_code_seen,
    input  wire logic                       xfer_ack_fault,
    input  wire logic [3:0]                 xfer_ack,
    // Page-table access completion
    input  wire logic                       page_done,
    input  wire logic [3:0]                 page_state,
    input  wire logic [3:0]                 page_response_code_seen,
    input  wire logic                       page_ack_fault,
    input  wire logic [3:0]                 page_ack,
    input  wire logic [15:0]                page_number,
    input  wire logic [15:0]                page_length,
    input  wire logic [15:0]                page_table_upper,
    input  wire logic [31:0]                page_table_lower,
    // Control seen by the packetizer
    output logic      [1:0]                 header_view_select,
    output logic                            read_packetizer_enable,
    output logic                            transmit_packetizer_enable,
    // Header fields seen by the packetizer
    output logic      [1:0]                 read_req_speed,
    output logic      [5:0]                 read_req_label,
    output logic      [1:0]                 read_req_retry_code,
    output logic      [3:0]                 read_req_tcode,
    output logic      [3:0]                 read_req_priority,
    output logic      [15:0]                read_req_dest_node,
    output logic      [15:0]                read_req_dest_offset_upper,
    output logic      [31:0]                read_req_dest_offset_lower,
    output logic      [15:0]                read_req_length,
    output logic      [15:0]                read_req_ext_tcode
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic        wr_strobe;
    logic        rd_setup;
    logic        hit_ctrl;
    logic [3:0]  hit_word;
    logic        view_hdr;
    logic        view_stat;
    logic        hdr_wr_ok;
    logic [31:0] hdr_w0;
    logic [31:0] hdr_w1;
    logic [31:0] hdr_w2;
    logic [31:0] hdr_w3;
    logic [31:0] st_w0;
    logic [31:0] st_w1;
    logic [31:0] st_w2;
    logic [31:0] st_w3;
    logic        w0_le;
    logic [31:0] w0_next;
    logic        st0_le;
    logic [31:0] st0_next;
    logic [31:0] st1_next;
    logic [31:0] st2_next;
    logic [31:0] rd_next;

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    rrh_apb_if u_apb (
        .psel      (psel),
        .penable   (penable),
        .pwrite    (pwrite),
        .paddr     (paddr),
        .wr_strobe (wr_strobe),
        .rd_setup  (rd_setup),
        .hit_ctrl  (hit_ctrl),
        .hit_word  (hit_word),
        .pready    (pready),
        .pslverr   (pslverr)
    );

    // ------------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            header_view_select         <= 2'h0;
            read_packetizer_enable     <= 1'b0;
            transmit_packetizer_enable <= 1'b0;
        end else if (wr_strobe && hit_ctrl) begin
            header_view_select <=
                pwdata[rrh_pkg::CTRL_SEL_HI:rrh_pkg::CTRL_SEL_LO];
            read_packetizer_enable     <= pwdata[rrh_pkg::CTRL_RPK];
            transmit_packetizer_enable <= pwdata[rrh_pkg::CTRL_TPK];
        end
    end

    assign view_hdr  = (header_view_select == rrh_pkg::VIEW_HEADER); // [R1]
    assign view_stat = (header_view_select == rrh_pkg::VIEW_STATUS); // [R2]

    // Header words 1-3 accept software writes only in the header view.
    assign hdr_wr_ok = wr_strobe & view_hdr & ~transmit_packetizer_enable; // [R15]

    // ------------------------------------------------------------------
    // Header word 0
    // ------------------------------------------------------------------
    // Loaded by the packetizer; tCode is held at the read code while the
    // read packetizer runs; the old value still goes out for the one cycle after the enable is set.
    always_comb begin
        w0_next = hdr_w0;
        w0_le   = hdr_load | read_packetizer_enable;
        if (hdr_load) begin
            w0_next[rrh_pkg::SPD_HI:rrh_pkg::SPD_LO] = hdr_speed;    // [R6]
            w0_next[rrh_pkg::LBL_HI:rrh_pkg::LBL_LO] = hdr_label;    // [R7]
            w0_next[rrh_pkg::RTY_HI:rrh_pkg::RTY_LO] = hdr_retry;    // [R8]
            w0_next[rrh_pkg::TC_HI:rrh_pkg::TC_LO]   = hdr_tcode;
            w0_next[rrh_pkg::PRI_HI:rrh_pkg::PRI_LO] = hdr_priority; // [R10]
        end
        if (read_packetizer_enable) begin
            w0_next[rrh_pkg::TC_HI:rrh_pkg::TC_LO] = rrh_pkg::TCODE_READ; // [R9]
        end
    end

    rrh_word_reg #(
        .W     (32),
        .RESET (rrh_pkg::RST_WORD0)
    ) u_hdr_w0 ( // [R5]
        .pclk     (pclk),
        .presetn  (presetn),
        .sw_we    (1'b0),
        .sw_wdata (pwdata),
        .hw_le    (w0_le),
        .hw_data  (w0_next),
        .q        (hdr_w0)
    );

    // ------------------------------------------------------------------
    // Header words 1-3
    // ------------------------------------------------------------------
    // Only presetn resets these; there is no bus-reset input at all.
    rrh_word_reg #(
        .W     (32),
        .RESET (rrh_pkg::RST_ZERO)
    ) u_hdr_w1 ( // [R3] [R11]
        .pclk     (pclk),
        .presetn  (presetn),
        .sw_we    (hdr_wr_ok & hit_word[1]),
        .sw_wdata (pwdata),
        .hw_le    (1'b0),
        .hw_data  (pwdata),
        .q        (hdr_w1)
    );

    rrh_word_reg #(
        .W     (32),
        .RESET (rrh_pkg::RST_ZERO)
    ) u_hdr_w2 ( // [R12]
        .pclk     (pclk),
        .presetn  (presetn),
        .sw_we    (hdr_wr_ok & hit_word[2]),
        .sw_wdata (pwdata),
        .hw_le    (1'b0),
        .hw_data  (pwdata),
        .q        (hdr_w2)
    );

    rrh_word_reg #(
        .W     (32),
        .RESET (rrh_pkg::RST_WORD3)
    ) u_hdr_w3 ( // [R13] [R14]
        .pclk     (pclk),
        .presetn  (presetn),
        .sw_we    (hdr_wr_ok & hit_word[3]),
        .sw_wdata (pwdata),
        .hw_le    (1'b0),
        .hw_data  (pwdata),
        .q        (hdr_w3)
    );

    // ------------------------------------------------------------------
    // Status words
    // ------------------------------------------------------------------
    // Both completions may land in one cycle; each owns its own fields.
    always_comb begin
        st0_next = st_w0;
        st0_le   = xfer_done | page_done;
        if (xfer_done) begin
            st0_next[rrh_pkg::ST_HI:rrh_pkg::ST_LO]   = xfer_state; // [R16]
            st0_next[rrh_pkg::RSP_HI:rrh_pkg::RSP_LO] = xfer_response_code_seen;
            st0_next[rrh_pkg::ACKF_BIT]               = xfer_ack_fault;
            st0_next[rrh_pkg::ACK_HI:rrh_pkg::ACK_LO] = xfer_ack;
        end
        if (page_done) begin
            st0_next[rrh_pkg::PST_HI:rrh_pkg::PST_LO]   = page_state;
            st0_next[rrh_pkg::PRS_HI:rrh_pkg::PRS_LO]   = page_response_code_seen;
            st0_next[rrh_pkg::PACKF_BIT]                = page_ack_fault;
            st0_next[rrh_pkg::PAGE_ACK_CODE_HI:rrh_pkg::PAGE_ACK_CODE_LO] = page_ack;
        end
    end

    always_comb begin
        st1_next = st_w1;
        st1_next[rrh_pkg::UPR_HI:rrh_pkg::UPR_LO] = page_number;
        st2_next = {page_length, page_table_upper};
    end

    rrh_word_reg #(
        .W     (32),
        .RESET (rrh_pkg::RST_ZERO)
    ) u_st_w0 ( // [R4] [R17]
        .pclk     (pclk),
        .presetn  (presetn),
        .sw_we    (1'b0),
        .sw_wdata (pwdata),
        .hw_le    (st0_le),
        .hw_data  (st0_next),
        .q        (st_w0)
    );

    rrh_word_reg #(
        .W     (32),
        .RESET (rrh_pkg::RST_ZERO)
    ) u_st_w1 ( // [R17]
        .pclk     (pclk),
        .presetn  (presetn),
        .sw_we    (1'b0),
        .sw_wdata (pwdata),
        .hw_le    (page_done),
        .hw_data  (st1_next),
        .q        (st_w1)
    );

    rrh_word_reg #(
        .W     (32),
        .RESET (rrh_pkg::RST_ZERO)
    ) u_st_w2 ( // [R17]
        .pclk     (pclk),
        .presetn  (presetn),
        .sw_we    (1'b0),
        .sw_wdata (pwdata),
        .hw_le    (page_done),
        .hw_data  (st2_next),
        .q        (st_w2)
    );

    rrh_word_reg #(
        .W     (32),
        .RESET (rrh_pkg::RST_ZERO)
    ) u_st_w3 ( // [R17]
        .pclk     (pclk),
        .presetn  (presetn),
        .sw_we    (1'b0),
        .sw_wdata (pwdata),
        .hw_le    (page_done),
        .hw_data  (page_table_lower),
        .q        (st_w3)
    );

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    // Selected in the setup phase so the access phase answers at once.
    always_comb begin
        rd_next = rrh_pkg::RST_ZERO;
        if (hit_ctrl) begin
            rd_next[rrh_pkg::CTRL_SEL_HI:rrh_pkg::CTRL_SEL_LO] =
                header_view_select;
            rd_next[rrh_pkg::CTRL_RPK] = read_packetizer_enable;
            rd_next[rrh_pkg::CTRL_TPK] = transmit_packetizer_enable;
        end else if (view_hdr) begin // [R1]
            case (1'b1)
                hit_word[0]: rd_next = hdr_w0;
                hit_word[1]: rd_next = hdr_w1;
                hit_word[2]: rd_next = hdr_w2;
                hit_word[3]: rd_next = hdr_w3;
                default:     rd_next = rrh_pkg::RST_ZERO;
            endcase
        end else if (view_stat) begin // [R2]
            case (1'b1)
                hit_word[0]: rd_next = st_w0;
                hit_word[1]: rd_next = st_w1;
                hit_word[2]: rd_next = st_w2;
                hit_word[3]: rd_next = st_w3;
                default:     rd_next = rrh_pkg::RST_ZERO;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= rrh_pkg::RST_ZERO;
        end else if (rd_setup) begin
            prdata <= rd_next;
        end
    end

    // ------------------------------------------------------------------
    // Header fields to the packetizer
    // ------------------------------------------------------------------
    assign read_req_speed      = hdr_w0[rrh_pkg::SPD_HI:rrh_pkg::SPD_LO];
    assign read_req_label      = hdr_w0[rrh_pkg::LBL_HI:rrh_pkg::LBL_LO];
    assign read_req_retry_code = hdr_w0[rrh_pkg::RTY_HI:rrh_pkg::RTY_LO];
    assign read_req_tcode      = hdr_w0[rrh_pkg::TC_HI:rrh_pkg::TC_LO];
    assign read_req_priority   = hdr_w0[rrh_pkg::PRI_HI:rrh_pkg::PRI_LO];
    assign read_req_dest_node  = hdr_w1[rrh_pkg::UPR_HI:rrh_pkg::UPR_LO];
    assign read_req_dest_offset_upper =
        hdr_w1[rrh_pkg::LWR_HI:rrh_pkg::LWR_LO];
    assign read_req_dest_offset_lower = hdr_w2;
    assign read_req_length     = hdr_w3[rrh_pkg::UPR_HI:rrh_pkg::UPR_LO];
    assign read_req_ext_tcode  = hdr_w3[rrh_pkg::LWR_HI:rrh_pkg::LWR_LO];

endmodule

// File: include/rrh_pkg.sv
// Constants for the read-request header and read-path status register bank.
// Assumes a 32-bit APB slave with byte addresses and one word per register.
package rrh_pkg;

    // ------------------------------------------------------------------
    // Bus and register map
    // ------------------------------------------------------------------
    localparam int         ADDR_W      = 8;
    localparam int         DATA_W      = 32;
    localparam logic [7:0] OFS_CTRL    = 8'h90;
    localparam logic [7:0] OFS_WORD0   = 8'he8;
    localparam logic [7:0] OFS_WORD1   = 8'hec;
    localparam logic [7:0] OFS_WORD2   = 8'hf0;
    localparam logic [7:0] OFS_WORD3   = 8'hf4;

    // ------------------------------------------------------------------
    // Control register layout and view codes
    // ------------------------------------------------------------------
    localparam int         CTRL_SEL_LO = 0;
    localparam int         CTRL_SEL_HI = 1;
    localparam int         CTRL_RPK    = 2;
    localparam int         CTRL_TPK    = 3;
    localparam logic [1:0] VIEW_HEADER = 2'h2;
    localparam logic [1:0] VIEW_STATUS = 2'h3;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [31:0] RST_WORD0  = 32'h0001_0010;
    localparam logic [31:0] RST_WORD3  = 32'h0008_0000;
    localparam logic [31:0] RST_ZERO   = 32'h0000_0000;
    localparam logic [3:0]  TCODE_READ = 4'h1;

    // ------------------------------------------------------------------
    // Header word fields (hardware bit positions, bit 31 is the MSB)
    // ------------------------------------------------------------------
    localparam int SPD_HI   = 17;
    localparam int SPD_LO   = 16;
    localparam int LBL_HI   = 15;
    localparam int LBL_LO   = 10;
    localparam int RTY_HI   = 9;
    localparam int RTY_LO   = 8;
    localparam int TC_HI    = 7;
    localparam int TC_LO    = 4;
    localparam int PRI_HI   = 3;
    localparam int PRI_LO   = 0;
    localparam int UPR_HI   = 31;
    localparam int UPR_LO   = 16;
    localparam int LWR_HI   = 15;
    localparam int LWR_LO   = 0;

    // ------------------------------------------------------------------
    // Status word 0 fields
    // ------------------------------------------------------------------
    localparam int ST_HI    = 31;
    localparam int ST_LO    = 28;
    localparam int RSP_HI   = 27;
    localparam int RSP_LO   = 24;
    localparam int ACKF_BIT = 20;
    localparam int ACK_HI   = 19;
    localparam int ACK_LO   = 16;
    localparam int PST_HI   = 15;
    localparam int PST_LO   = 12;
    localparam int PRS_HI   = 11;
    localparam int PRS_LO   = 8;
    localparam int PACKF_BIT = 4;
    localparam int PAGE_ACK_CODE_HI  = 3;
    localparam int PAGE_ACK_CODE_LO  = 0;

    // ------------------------------------------------------------------
    // Completion state codes
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        RRH_DONE_OK        = 4'h0,
        RRH_DONE_SPLIT     = 4'h1,
        RRH_DONE_OTHER_ACK = 4'h2,
        RRH_DONE_PAGE_FAIL = 4'h4,
        RRH_DONE_RETRY_LIM = 4'h7,
        RRH_DONE_BAD_RCODE = 4'ha,
        RRH_DONE_SPLIT_TMO = 4'hb,
        RRH_DONE_BUS_RESET = 4'hc,
        RRH_DONE_CLEARED   = 4'hd
    } rrh_done_t;

endpackage

// File: core/rrh_word_reg.sv
// One 32-bit register word with a software write port and a hardware load.
// Assumes both ports are synchronous to pclk; the hardware load wins.
`timescale 1ns/10ps
module rrh_word_reg #(
    parameter int          W     = 32,
    parameter logic [31:0] RESET = 32'h0000_0000
) (
    // Clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // Software port
    input  wire logic         sw_we,
    input  wire logic [W-1:0] sw_wdata,
    // Hardware port
    input  wire logic         hw_le,
    input  wire logic [W-1:0] hw_data,
    // Stored value
    output logic      [W-1:0] q
);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= RESET[W-1:0];
        end else if (hw_le) begin
            q <= hw_data;
        end else if (sw_we) begin
            q <= sw_wdata;
        end
    end

endmodule

// File: core/rrh_apb_if.sv
// APB3 decode for the register bank: strobes, word hits and the answer.
// Assumes a zero-wait slave; read data is registered in the setup phase.
`timescale 1ns/10ps
module rrh_apb_if (
    // APB request
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [rrh_pkg::ADDR_W-1:0] paddr,
    // Decoded strobes
    output logic                           wr_strobe,
    output logic                           rd_setup,
    output logic                           hit_ctrl,
    output logic [3:0]                     hit_word,
    // APB answer
    output logic                           pready,
    output logic                           pslverr
);

    logic mapped;

    assign hit_ctrl    = (paddr == rrh_pkg::OFS_CTRL);
    assign hit_word[0] = (paddr == rrh_pkg::OFS_WORD0);
    assign hit_word[1] = (paddr == rrh_pkg::OFS_WORD1);
    assign hit_word[2] = (paddr == rrh_pkg::OFS_WORD2);
    assign hit_word[3] = (paddr == rrh_pkg::OFS_WORD3);
    assign mapped      = hit_ctrl | (|hit_word);
    assign wr_strobe   = psel & penable & pwrite & mapped;
    assign rd_setup    = psel & ~penable & ~pwrite;
    assign pready      = 1'b1;
    assign pslverr     = psel & penable & ~mapped;

endmodule

// File: verif/rrh_regs_checker.sv
// Assertions on the ports of the header register bank.
// Assumes a bind to rrh_regs; every signal is on pclk.
`timescale 1ns/10ps
module rrh_regs_checker (
    // Bus
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    // Packetizer side
    input wire logic        hdr_load,
    input wire logic [3:0]  hdr_tcode,
    input wire logic [1:0]  header_view_select,
    input wire logic        read_packetizer_enable,
    input wire logic        transmit_packetizer_enable,
    input wire logic [3:0]  read_req_tcode,
    input wire logic [15:0] read_req_length,
    input wire logic [15:0] read_req_ext_tcode
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_rd(a);
        psel && penable && !pwrite && paddr == a;
    endsequence
    sequence s_wr(a);
        psel && penable && pwrite && paddr == a;
    endsequence
    a_view_hidden: assert property (
        s_rd(8'he8) ##0 header_view_select < 2'h2 |-> prdata == 32'h0)
        else $error("header word shown outside its view");
    a_ctrl_write: assert property (
        s_wr(8'h90) |=> header_view_select == $past(pwdata[1:0]))
        else $error("view select not written");
    a_word3_view: assert property (
        s_rd(8'hf4) ##0 header_view_select == 2'h2
        |-> prdata == {read_req_length, read_req_ext_tcode})
        else $error("word 3 read differs from its fields");
    a_tcode_forced: assert property (
        read_packetizer_enable |=> read_req_tcode == 4'h1)
        else $error("tcode not forced");
    a_tcode_held: assert property (
        read_packetizer_enable [*2] |-> read_req_tcode == 4'h1)
        else $error("tcode left the forced value");
    a_tcode_load: assert property (
        hdr_load && !read_packetizer_enable
        |=> read_req_tcode == $past(hdr_tcode))
        else $error("tcode not loaded");
    a_len_locked: assert property (
        transmit_packetizer_enable
        |=> $stable({read_req_length, read_req_ext_tcode}))
        else $error("word 3 changed while locked");
    a_len_write: assert property (
        s_wr(8'hf4) ##0 header_view_select == 2'h2
        ##0 !transmit_packetizer_enable
        |=> read_req_length == $past(pwdata[31:16]))
        else $error("length not written");
endmodule
bind rrh_regs rrh_regs_checker chk_u (.*);

// File: verif/rrh_regs_test.sv
// Self-checking bench for the header register bank.
// Assumes the checker binds itself; the bench plays the packetizer.
`timescale 1ns/10ps
module rrh_regs_test;
    // --------
    // Signals
    // --------
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0;
    logic        penable = 1'b0, pwrite = 1'b0, pready, pslverr, rerr;
    logic        hdr_load = 1'b0, xfer_done = 1'b0, page_done = 1'b0;
    logic        xfer_ack_fault = 1'b0, page_ack_fault = 1'b0;
    logic        read_packetizer_enable, transmit_packetizer_enable;
    logic [1:0]  hdr_speed = 2'h0, hdr_retry = 2'h0, header_view_select;
    logic [1:0]  read_req_speed, read_req_retry_code;
    logic [3:0]  hdr_tcode = 4'h0, hdr_priority = 4'h0, xfer_ack = 4'h0;
    logic [3:0]  xfer_state = 4'h0, xfer_response_code_seen = 4'h0, page_ack = 4'h0;
    logic [3:0]  page_state = 4'h0, page_response_code_seen = 4'h0;
    logic [3:0]  read_req_tcode, read_req_priority;
    logic [5:0]  hdr_label = 6'h0, read_req_label;
    logic [7:0]  paddr = 8'h0;
    logic [15:0] page_number = 16'h0, page_length = 16'h0;
    logic [15:0] page_table_upper = 16'h0, read_req_dest_node;
    logic [15:0] read_req_dest_offset_upper, read_req_length;
    logic [15:0] read_req_ext_tcode;
    logic [31:0] pwdata = 32'h0, page_table_lower = 32'h0, prdata, rdat;
    logic [31:0] read_req_dest_offset_lower;
    logic [3:0]  codes [9] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h7, 4'ha,
                               4'hb, 4'hc, 4'hd};
    int          failures = 0;
    int          samples_checked = 0;

    rrh_regs dut_u (.*);

    initial begin
        forever #5 pclk = ~pclk;
    end

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            failures++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(rdat, e);
    endtask

    task automatic give_verdict;
        $display("compares %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // --------
    // Tests
    // --------
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rchk(8'he8, 32'h0);
        bus(1'b1, 8'h90, 32'h2);
        rchk(8'he8, 32'h0001_0010);
        rchk(8'hf0, 32'h0);
        rchk(8'hf4, 32'h0008_0000);
        rchk(8'h40, 32'h0);
        chk({31'h0, rerr}, 32'h1);
        $display("test reset values done");
        bus(1'b1, 8'hec, 32'hffc0_1234);
        bus(1'b1, 8'hf0, 32'h8765_4321);
        bus(1'b1, 8'hf4, 32'h0040_0021);
        bus(1'b1, 8'he8, 32'hffff_ffff);
        rchk(8'hec, 32'hffc0_1234);
        rchk(8'hf0, 32'h8765_4321);
        rchk(8'he8, 32'h0001_0010);
        chk({read_req_length, read_req_ext_tcode}, 32'h0040_0021);
        bus(1'b1, 8'h90, 32'ha);
        bus(1'b1, 8'hf4, 32'h0);
        rchk(8'hf4, 32'h0040_0021);
        $display("test header writes done");
        bus(1'b1, 8'h90, 32'h2);
        {hdr_speed, hdr_label, hdr_retry, hdr_tcode, hdr_priority}
            <= {2'h2, 6'h2a, 2'h3, 4'h5, 4'h9};
        hdr_load <= 1'b1;
        @(posedge pclk);
        hdr_load <= 1'b0;
        rchk(8'he8, 32'h0002_ab59);
        bus(1'b1, 8'h90, 32'h6);
        hdr_load <= 1'b1;
        @(posedge pclk);
        hdr_load <= 1'b0;
        rchk(8'he8, 32'h0002_ab19);
        $display("test header load done");
        bus(1'b1, 8'h90, 32'h3);
        foreach (codes[i]) begin
            {xfer_state, xfer_response_code_seen, xfer_ack_fault, xfer_ack}
                <= {codes[i], ~codes[i], 1'b1, 4'h6};
            xfer_done <= 1'b1;
            @(posedge pclk);
            xfer_done <= 1'b0;
            rchk(8'he8, {codes[i], ~codes[i], 4'h1, 4'h6, 16'h0});
        end
        {page_state, page_response_code_seen, page_ack_fault, page_ack}
            <= {4'h4, 4'h2, 1'b1, 4'h7};
        {page_number, page_length, page_table_upper}
            <= {16'h12, 16'h200, 16'hffff};
        page_table_lower <= 32'h1234_5678;
        page_done <= 1'b1;
        @(posedge pclk);
        page_done <= 1'b0;
        bus(1'b1, 8'hf4, 32'h0);
        rchk(8'he8, 32'hd216_4217);
        rchk(8'hf0, 32'h0200_ffff);
        rchk(8'hf4, 32'h1234_5678);
        bus(1'b1, 8'h90, 32'h2);
        rchk(8'hf4, 32'h0040_0021);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        bus(1'b1, 8'h90, 32'h3);
        rchk(8'he8, 32'h0);
        $display("test status view done");
        give_verdict;
    end

    // The tests take well under a thousand cycles.
    initial begin
        #100000;
        failures++;
        give_verdict;
    end
endmodule
